// ### fcpwm_pkg.sv
// Package for the four-channel PWM with brake.
// Assumes an APB slave with 32-bit data; register index times four is the byte address.
package fcpwm_pkg;

   localparam int unsigned CNT_W    = 10;
   localparam int unsigned NCH      = 4;
   localparam int unsigned ADDR_W   = 12;

   // Register indexes
   localparam logic [7:0] RELOAD_HOLD_IDX = 8'hD0;
   localparam logic [7:0] STATUS_IDX      = 8'hD1;
   localparam logic [7:0] CMP_HOLD_IDX0   = 8'hD4;
   localparam logic [7:0] RUN_TRANSFER_REQUEST_IDX    = 8'hDA;
   localparam logic [7:0] BRAKE_CTL_IDX   = 8'hDB;

   // Field positions in the run and transfer control register
   localparam int unsigned RUN_BIT  = 7;
   localparam int unsigned TRANSFER_REQUEST_BIT = 6;
   localparam int unsigned INV_LSB  = 0;

   // Field positions in the status register
   localparam int unsigned STAT_BRAKE_BIT = 16;
   localparam int unsigned STAT_OUT_LSB   = 12;

   // Reset values and special compare values
   localparam logic [9:0] RELOAD_RST   = 10'h3FF;
   localparam logic [9:0] CMP_RST      = 10'h000;
   localparam logic [9:0] CMP_ALL_ONES = 10'h3FF;
   localparam logic [9:0] CMP_ZERO     = 10'h000;
   localparam logic [7:0] BRAKE_RST    = 8'h00;
   localparam logic [3:0] RAW_RST      = 4'hF;

   typedef struct packed {
      logic       brake_on_halt_select;
      logic       brake_pin_polarity;
      logic       brake_pin_select;
      logic       brake_enable;
      logic [3:0] brake_level;
   } fcpwm_brake_ctl_t;

   typedef struct packed {
      logic       run;
      logic       transfer_request;
      logic [3:0] invert;
   } fcpwm_run_ctl_t;

endpackage

// ### fcpwm_top.sv
// Four-channel 10-bit PWM generator with brake, APB register slave.
// Assumes brake_pin_i is asynchronous to clk_i; all other inputs are on clk_i.
// Notes on behaviour
// - One 10-bit down counter times each period, reloading at underflow.
// - Underflow drives output high; reaching compare drives it low until next underflow.
// - After reset every channel's internal output is one.
// - Compare above reload, other than all ones, keeps the output high.
// - Compare of zero keeps the output high.
// - Compare of all ones keeps the output low.
// - Compare writes go to holding registers; working ones change only by transfer.
// - Per-channel invert bit gives the opposite waveform.
// - Transfer only at underflow with request set; hardware then clears request.
// - With run clear the transfer never happens.
// - Writing run without transfer before underflow cancels the pending transfer.
// - Clearing run halts the counter and freezes the outputs.
// - Brake forces each output to its own programmed level.
// - No brake while brake enable is zero; select bits choose the source.
// - Both select bits zero means brake always, pin ignored.
// - Halt source brakes while run is zero.
// - Pin source brakes while pin level equals the polarity bit.
// - Pin-caused brake clears the run bit.
// - Removing brake returns outputs to their pre-brake levels.
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none

module fcpwm_top
   import fcpwm_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   input  wire logic              en_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic              brake_pin_i,
   output logic      [NCH-1:0]    pwm_o
);

   function automatic logic [9:0] idx_of(input logic [ADDR_W-1:0] a);
      idx_of = a[ADDR_W-1:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   logic [CNT_W-1:0]            cnt_q;
   logic [CNT_W-1:0]            reload_hold_q;
   logic [CNT_W-1:0]            reload_work_q;
   logic [NCH-1:0][CNT_W-1:0]   cmp_hold_q;
   logic [NCH-1:0][CNT_W-1:0]   cmp_work_q;
   logic [NCH-1:0]              raw_q;
   fcpwm_run_ctl_t              ctl_q;
   fcpwm_brake_ctl_t            bk_q;
   logic                        pin_s1_q;
   logic                        pin_s2_q;
   logic [31:0]                 prdata_q;
   logic                        pready_q;
   logic                        pslverr_q;
   logic [NCH-1:0]              pwm_q;

   logic                        acc_w;
   logic                        wr_w;
   logic [9:0]                  idx_w;
   logic                        uflow_w;
   logic                        transfer_request_now_w;
   logic                        pin_brake_w;
   logic                        brake_w;
   logic [31:0]                 rdata_w;
   logic                        hit_w;

   assign acc_w   = psel_i && penable_i && !pready_q;
   // Writes land at the completing edge, when the master samples pready high
   assign wr_w    = psel_i && penable_i && pready_q && pwrite_i;
   assign idx_w   = idx_of(paddr_i);
   assign uflow_w = ctl_q.run && (cnt_q == '0);
   assign transfer_request_now_w = uflow_w && ctl_q.transfer_request;

   ////////////////////////////////////////////////////////////////////////
   // Brake condition

   assign pin_brake_w = bk_q.brake_enable && bk_q.brake_pin_select
                        && !bk_q.brake_on_halt_select
                        && (pin_s2_q == bk_q.brake_pin_polarity);

   // Both selects set is forbidden; it is treated as no brake.
   always_comb begin
      brake_w = 1'b0;
      if (bk_q.brake_enable) begin
         case ({bk_q.brake_pin_select, bk_q.brake_on_halt_select})
            2'b00:   brake_w = 1'b1;
            2'b01:   brake_w = !ctl_q.run;
            2'b10:   brake_w = pin_brake_w;
            default: brake_w = 1'b0;
         endcase
      end
   end

   // Pin synchroniser; the first stage feeds only the second.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else if (en_i) begin
         pin_s1_q <= brake_pin_i;
         pin_s2_q <= pin_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter and working registers

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= RELOAD_RST;
      end else if (en_i && ctl_q.run) begin
         if (cnt_q == '0) begin
            cnt_q <= transfer_request_now_w ? reload_hold_q : reload_work_q;
         end else begin
            cnt_q <= cnt_q - 10'h001;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reload_work_q <= RELOAD_RST;
         cmp_work_q    <= {NCH{CMP_RST}};
      end else if (en_i && transfer_request_now_w) begin
         reload_work_q <= reload_hold_q;
         cmp_work_q    <= cmp_hold_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel waveforms

   // Raw levels freeze while halted or braked, so ending a brake restores them.
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic [CNT_W-1:0] cmp_next;
      assign cmp_next = transfer_request_now_w ? cmp_hold_q[i] : cmp_work_q[i];

      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            raw_q[i] <= RAW_RST[i];
         end else if (en_i && ctl_q.run && !brake_w) begin
            if (uflow_w) begin
               raw_q[i] <= (cmp_next != CMP_ALL_ONES);
            end else if (cmp_work_q[i] == CMP_ALL_ONES) begin
               raw_q[i] <= 1'b0;
            end else if ((cnt_q == cmp_work_q[i]) && (cmp_work_q[i] != CMP_ZERO)) begin
               // Compare above reload is never met, so output stays high
               raw_q[i] <= 1'b0;
            end
         end
      end

      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            pwm_q[i] <= RAW_RST[i];
         end else if (en_i) begin
            pwm_q[i] <= brake_w ? bk_q.brake_level[i]
                                : raw_q[i] ^ ctl_q.invert[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers written by software

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctl_q <= '0;
      end else if (en_i) begin
         if (wr_w && idx_w == 10'(RUN_TRANSFER_REQUEST_IDX)) begin
            ctl_q.run              <= pwdata_i[RUN_BIT];
            ctl_q.transfer_request <= pwdata_i[TRANSFER_REQUEST_BIT];
            ctl_q.invert           <= pwdata_i[INV_LSB +: NCH];
         end else if (transfer_request_now_w) begin
            ctl_q.transfer_request <= 1'b0;
         end
         // Hardware clear of run beats a same-cycle software set
         if (pin_brake_w) begin
            ctl_q.run <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bk_q          <= BRAKE_RST;
         reload_hold_q <= RELOAD_RST;
         cmp_hold_q    <= {NCH{CMP_RST}};
      end else if (en_i && wr_w) begin
         if (idx_w == 10'(BRAKE_CTL_IDX)) begin
            bk_q <= pwdata_i[7:0];
         end
         if (idx_w == 10'(RELOAD_HOLD_IDX)) begin
            reload_hold_q <= pwdata_i[CNT_W-1:0];
         end
         for (int c = 0; c < NCH; c++) begin
            if (idx_w == 10'(CMP_HOLD_IDX0) + 10'(c)) begin
               cmp_hold_q[c] <= pwdata_i[CNT_W-1:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB read path, one wait state per transfer

   always_comb begin
      rdata_w = '0;
      hit_w   = 1'b1;
      case (idx_w)
         10'(RUN_TRANSFER_REQUEST_IDX): begin
            rdata_w[RUN_BIT]            = ctl_q.run;
            rdata_w[TRANSFER_REQUEST_BIT]           = ctl_q.transfer_request;
            rdata_w[INV_LSB +: NCH]     = ctl_q.invert;
         end
         10'(BRAKE_CTL_IDX):   rdata_w[7:0]       = bk_q;
         10'(RELOAD_HOLD_IDX): rdata_w[CNT_W-1:0] = reload_hold_q;
         10'(STATUS_IDX): begin
            rdata_w[CNT_W-1:0]             = cnt_q;
            rdata_w[STAT_OUT_LSB +: NCH]   = pwm_q;
            rdata_w[STAT_BRAKE_BIT]        = brake_w;
         end
         default: begin
            if (idx_w >= 10'(CMP_HOLD_IDX0) && idx_w < 10'(CMP_HOLD_IDX0) + 10'(NCH)) begin
               rdata_w[CNT_W-1:0] = cmp_hold_q[2'(idx_w - 10'(CMP_HOLD_IDX0))];
            end else begin
               hit_w = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else if (en_i) begin
         pready_q  <= acc_w;
         pslverr_q <= acc_w && !hit_w;
         prdata_q  <= (acc_w && !pwrite_i) ? rdata_w : '0;
      end
   end

   assign prdata_o  = prdata_q;
   assign pready_o  = pready_q;
   assign pslverr_o = pslverr_q;
   assign pwm_o     = pwm_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   cnt_reload_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && uflow_w && !ctl_q.transfer_request |=> cnt_q == $past(reload_work_q))
      else $error("counter did not reload at underflow");

   transfer_request_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && transfer_request_now_w && !(wr_w && idx_w == 10'(RUN_TRANSFER_REQUEST_IDX))
      |=> !ctl_q.transfer_request && reload_work_q == $past(reload_hold_q))
      else $error("transfer did not complete or clear");

   shadow_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !(en_i && transfer_request_now_w) |=> $stable(cmp_work_q) && $stable(reload_work_q))
      else $error("working registers changed without transfer");

   halt_freeze_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !ctl_q.run |=> $stable(cnt_q) && $stable(raw_q))
      else $error("counter moved while halted");

   brake_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && brake_w |=> pwm_q == $past(bk_q.brake_level))
      else $error("brake level not driven");

   brake_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && !bk_q.brake_enable |=> pwm_q == $past(raw_q ^ ctl_q.invert))
      else $error("output not the waveform with brake disabled");

   pin_run_clr_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && pin_brake_w |=> !ctl_q.run)
      else $error("pin brake left run set");

   ones_low_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && ctl_q.run && !brake_w && !transfer_request_now_w && cmp_work_q[0] == CMP_ALL_ONES
      |=> !raw_q[0])
      else $error("all-ones compare did not hold output low");

   zero_high_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && !transfer_request_now_w && cmp_work_q[0] == CMP_ZERO && raw_q[0] |=> raw_q[0])
      else $error("zero compare let output fall");

   apb_wait_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      en_i && acc_w |=> pready_q ##1 !pready_q || !psel_i)
      else $error("pready not given one cycle after access");

endmodule // fcpwm_top

`default_nettype wire

// ### fcpwm_far.sv
// Far-side model: loads on the four outputs and the driver of the brake pin.
// Assumes clk_i is the block clock; counts high cycles per channel between clears.
`timescale 1ns/10ps
`default_nettype none

module fcpwm_far
   import fcpwm_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   input  wire logic [NCH-1:0]    pwm_i,
   input  wire logic              clr_i,
   input  wire logic              brake_cmd_i,
   output logic                   brake_pin_o,
   output logic [NCH-1:0][3:0]    hi_cnt_o
);
   // The pin is a push-pull source, so it always shows a defined level
   assign brake_pin_o = brake_cmd_i;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hi_cnt_o <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            hi_cnt_o[i] <= clr_i ? 4'h0 : hi_cnt_o[i] + {3'h0, pwm_i[i]};
         end
      end
   end
endmodule // fcpwm_far

`default_nettype wire

// ### testbench.sv
// Self-checking bench: APB master tasks and directed sequences.
// Assumes one wait state per transfer but waits on pready with a bound.
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import fcpwm_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0]     paddr = '0;
   logic [31:0]           pwdata = '0, prdata, rd;
   logic                  pready, pslverr, err, brake_pin, brake_cmd = 1'b0, clr = 1'b0;
   logic [NCH-1:0]        pwm;
   logic [NCH-1:0][3:0]   hi_cnt;
   int                    miscompares = 0, samples_checked = 0;

   always #12.5 clk = ~clk;

   fcpwm_top uut (.clk_i(clk), .reset_n_i(reset_n), .en_i(1'b1), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .brake_pin_i(brake_pin), .pwm_o(pwm));
   fcpwm_far far (.clk_i(clk), .reset_n_i(reset_n), .pwm_i(pwm), .clr_i(clr),
      .brake_cmd_i(brake_cmd), .brake_pin_o(brake_pin), .hi_cnt_o(hi_cnt));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Eight cycles hold exactly two periods when reload is 3
   task automatic cnt8(input logic [15:0] exp);
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk({16'h0, hi_cnt[3], hi_cnt[2], hi_cnt[1], hi_cnt[0]}, {16'h0, exp});
   endtask

   task automatic transfer_request_wait();
      int n;
      n = 0;
      do begin
         apb(1'b0, RUN_TRANSFER_REQUEST_IDX, 32'h0);
         n++;
      end while (rd[TRANSFER_REQUEST_BIT] !== 1'b0 && n < 400);
      chk({31'h0, rd[TRANSFER_REQUEST_BIT]}, 32'h0);
      if (rd[TRANSFER_REQUEST_BIT] !== 1'b0) begin
         end_sim();
      end
   endtask

   task automatic pwm_is(input logic [3:0] exp);
      repeat (6) @(posedge clk);
      #1;
      chk({28'h0, pwm}, {28'h0, exp});
   endtask

   initial begin
      logic [31:0] s1;
      repeat (5) @(posedge clk);
      #1;
      chk({28'h0, pwm}, 32'h0000000F);
      reset_n <= 1'b1;
      apb(1'b0, BRAKE_CTL_IDX, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      $display("test reset done");
      ////////////////////////////////////////////////////////////////////
      apb(1'b1, RELOAD_HOLD_IDX, 32'h3);
      apb(1'b1, CMP_HOLD_IDX0, 32'h1);
      apb(1'b1, CMP_HOLD_IDX0 + 8'h1, 32'h0);
      apb(1'b1, CMP_HOLD_IDX0 + 8'h2, 32'h3FF);
      apb(1'b1, CMP_HOLD_IDX0 + 8'h3, 32'h5);
      apb(1'b1, RUN_TRANSFER_REQUEST_IDX, 32'hC0);
      transfer_request_wait();
      cnt8(16'h8086);
      apb(1'b1, RUN_TRANSFER_REQUEST_IDX, 32'h8F);
      cnt8(16'h0802);
      apb(1'b1, CMP_HOLD_IDX0, 32'h3FF);
      apb(1'b1, RUN_TRANSFER_REQUEST_IDX, 32'h80);
      cnt8(16'h8086);
      $display("test waveform done");
      ////////////////////////////////////////////////////////////////////
      apb(1'b1, RUN_TRANSFER_REQUEST_IDX, 32'h40);
      apb(1'b0, STATUS_IDX, 32'h0);
      s1 = rd;
      repeat (20) @(posedge clk);
      apb(1'b0, STATUS_IDX, 32'h0);
      chk(rd, s1);
      apb(1'b0, RUN_TRANSFER_REQUEST_IDX, 32'h0);
      chk(rd, 32'h40);
      apb(1'b1, RUN_TRANSFER_REQUEST_IDX, 32'h80);
      cnt8(16'h8086);
      apb(1'b1, RUN_TRANSFER_REQUEST_IDX, 32'hC0);
      transfer_request_wait();
      cnt8(16'h8080);
      $display("test transfer done");
      ////////////////////////////////////////////////////////////////////
      brake_cmd <= 1'b1;
      apb(1'b1, BRAKE_CTL_IDX, 32'h16);
      pwm_is(4'h6);
      apb(1'b1, BRAKE_CTL_IDX, 32'h95);
      pwm_is(4'hA);
      apb(1'b1, RUN_TRANSFER_REQUEST_IDX, 32'h00);
      pwm_is(4'h5);
      apb(1'b1, RUN_TRANSFER_REQUEST_IDX, 32'h80);
      apb(1'b1, BRAKE_CTL_IDX, 32'h63);
      pwm_is(4'hA);
      apb(1'b1, BRAKE_CTL_IDX, 32'h73);
      pwm_is(4'h3);
      apb(1'b0, RUN_TRANSFER_REQUEST_IDX, 32'h0);
      chk({31'h0, rd[RUN_BIT]}, 32'h0);
      brake_cmd <= 1'b0;
      pwm_is(4'hA);
      $display("test brake done");
      ////////////////////////////////////////////////////////////////////
      brake_cmd <= 1'b1;
      pwm_is(4'h3);
      apb(1'b1, BRAKE_CTL_IDX, 32'h1C);
      pwm_is(4'hC);
      apb(1'b1, CMP_HOLD_IDX0, 32'h3FF);
      apb(1'b1, CMP_HOLD_IDX0 + 8'h1, 32'h3FF);
      apb(1'b1, CMP_HOLD_IDX0 + 8'h2, 32'h0);
      apb(1'b1, CMP_HOLD_IDX0 + 8'h3, 32'h0);
      apb(1'b1, RUN_TRANSFER_REQUEST_IDX, 32'hC0);
      brake_cmd <= 1'b0;
      transfer_request_wait();
      apb(1'b1, CMP_HOLD_IDX0, 32'h1);
      apb(1'b1, CMP_HOLD_IDX0 + 8'h1, 32'h0);
      apb(1'b1, CMP_HOLD_IDX0 + 8'h2, 32'h3FF);
      apb(1'b1, CMP_HOLD_IDX0 + 8'h3, 32'h5);
      apb(1'b1, RUN_TRANSFER_REQUEST_IDX, 32'hC0);
      transfer_request_wait();
      pwm_is(4'hC);
      apb(1'b1, BRAKE_CTL_IDX, 32'h0C);
      // Channel 0 needs one underflow to leave its frozen level
      repeat (4) @(posedge clk);
      cnt8(16'h8086);
      $display("test recovery done");
      end_sim();
   end

   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      end_sim();
   end
endmodule // testbench

`default_nettype wire
